// ===== src/spi_engine_pkg.sv
// package: constants, register map and carrier types of the spi transfer engine
package spi_engine_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCK_HALF_NS   = 40;
	// least time, so round up
	localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_CONTROL_ONE = 8'h00;
	localparam logic [7:0] ADDR_CONTROL_TWO = 8'h04;
	localparam logic [7:0] ADDR_STATUS      = 8'h08;
	localparam logic [7:0] ADDR_DATA        = 8'h0c;

	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int C1_SAMPLE_PHASE = 0;
	localparam int C1_IDLE_LEVEL   = 1;
	localparam int C1_MASTER       = 2;
	localparam int C1_ENABLE       = 6;
	localparam int C1_BIT_ORDER    = 7;
	localparam int C1_RX_ONLY      = 10;
	localparam int C1_FRAME_LEN    = 11;
	localparam int C1_BIDIR_OE     = 14;
	localparam int C1_BIDIR_EN     = 15;
	localparam int C2_RXNE_IE      = 6;
	localparam int ST_RX_NE        = 0;
	localparam int ST_TX_EMPTY     = 1;
	localparam int ST_BUSY         = 7;
	localparam logic [15:0] CONTROL_ONE_RST = 16'h0000;
	localparam logic [15:0] CONTROL_TWO_RST = 16'h0000;

	typedef enum logic [1:0] {
		MODE_FULL_DUPLEX,
		MODE_RX_ONLY,
		MODE_BIDIR_TX,
		MODE_BIDIR_RX
	} line_mode_e;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} wb_req_s;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_s;

	typedef struct packed {
		logic sck;
		logic slave_select_n;
		logic mosi;
		logic miso;
	} spi_pins_in_s;

	typedef struct packed {
		logic sck_o;
		logic sck_oe;
		logic mosi_o;
		logic mosi_oe;
		logic miso_o;
		logic miso_oe;
	} spi_pins_out_s;

	typedef struct packed {
		logic [15:0]   control_one;
		logic [15:0]   control_two;
		logic [15:0]   tx_buf;
		logic          tx_empty_flag;
		logic [15:0]   rx_buf;
		logic          rx_not_empty_flag;
		logic [15:0]   tx_sr;
		logic [15:0]   rx_sr;
		logic [4:0]    bit_cnt;
		logic [5:0]    edge_cnt;
		logic [7:0]    div_cnt;
		logic          active;
		logic          sck_prev;
		logic          irq;
		spi_pins_out_s pins;
		wb_rsp_s       wb;
	} engine_state_s;

endpackage

// ===== src/spi_sync2.sv
// two-flop synchroniser for pins that arrive from outside the core clock domain
module spi_sync2
	import spi_engine_pkg::*;
#(
	parameter int WIDTH = 4
)
(
	// clock and reset
	input  wire logic             i_core_clk,
	input  wire logic             i_rst,
	// asynchronous in, synchronous out
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// the first stage feeds only the second stage
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;

endmodule

// ===== src/spi_engine.sv
// spi transfer engine: line modes, master and slave shifting, flags, wishbone registers
module spi_engine
	import spi_engine_pkg::*;
#(
	parameter int SCK_HALF = SCK_HALF_CYC
)
(
	// clock and reset
	input  wire logic          i_core_clk,
	input  wire logic          i_rst,
	// wishbone slave
	input  wire wb_req_s       i_wb,
	output wb_rsp_s            o_wb,
	// spi pins
	input  wire spi_pins_in_s  i_pins,
	output spi_pins_out_s      o_pins,
	// receive interrupt
	output logic               o_rx_irq
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic line_mode_e line_mode(input logic bidir_mode_enable,
		input logic bidir_output_enable, input logic receive_only_enable);
		if (bidir_mode_enable)
			return bidir_output_enable ? MODE_BIDIR_TX : MODE_BIDIR_RX;
		else
			return receive_only_enable ? MODE_RX_ONLY : MODE_FULL_DUPLEX;
	endfunction

	function automatic logic out_bit(input logic [15:0] sr, input logic lsb_first,
		input logic wide);
		if (lsb_first)
			return sr[0];
		else
			return wide ? sr[15] : sr[7];
	endfunction

	function automatic logic [15:0] tx_shift(input logic [15:0] sr, input logic lsb_first);
		return lsb_first ? {1'b0, sr[15:1]} : {sr[14:0], 1'b0};
	endfunction

	function automatic logic [15:0] rx_insert(input logic [15:0] sr, input logic b,
		input logic lsb_first, input logic wide);
		if (!lsb_first)
			return {sr[14:0], b};
		else if (wide)
			return {b, sr[15:1]};
		else
			return {8'h00, b, sr[7:1]};
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
		input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0])
			r[7:0] = dat[7:0];
		if (sel[1])
			r[15:8] = dat[15:8];
		return r;
	endfunction

	// ****************************************
	// pin synchronisers
	// ****************************************
	spi_pins_in_s pin_s;

	spi_sync2 #(
		.WIDTH ($bits(spi_pins_in_s))
	) u_sync (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_async    (i_pins),
		.o_sync     (pin_s)
	);

	// ****************************************
	// state
	// ****************************************
	engine_state_s s_q;
	engine_state_s s_d;

	line_mode_e  mode;
	logic        enabled;
	logic        master;
	logic        clock_idle_level;
	logic        clock_sample_phase;
	logic        lsb_first;
	logic        wide;
	logic [4:0]  len;
	logic        tx_mode;
	logic        rx_mode;
	logic        busy;
	logic        access;
	logic        wr;
	logic        start;
	logic        ev;
	logic        lead;
	logic        sample;
	logic        rx_bit;
	logic        tx_drive;
	logic [31:0] rdat;

	always_comb
	begin
		s_d = s_q;
		mode = line_mode(s_q.control_one[C1_BIDIR_EN], s_q.control_one[C1_BIDIR_OE],
			s_q.control_one[C1_RX_ONLY]);
		enabled = s_q.control_one[C1_ENABLE];
		master = s_q.control_one[C1_MASTER];
		clock_idle_level = s_q.control_one[C1_IDLE_LEVEL];
		clock_sample_phase = s_q.control_one[C1_SAMPLE_PHASE];
		lsb_first = s_q.control_one[C1_BIT_ORDER];
		wide = s_q.control_one[C1_FRAME_LEN];
		len = wide ? 5'd16 : 5'd8;
		tx_mode = (mode == MODE_FULL_DUPLEX) || (mode == MODE_BIDIR_TX);
		rx_mode = (mode == MODE_RX_ONLY) || (mode == MODE_BIDIR_RX);
		// a receive-only master keeps busy high for as long as it is enabled
		busy = s_q.active || (enabled && master && rx_mode);
		start = 1'b0;
		ev = 1'b0;
		lead = 1'b0;
		sample = 1'b0;
		rdat = 32'h0000_0000;
		// single shared line: the master's mosi or the slave's miso
		if (mode == MODE_BIDIR_TX || mode == MODE_BIDIR_RX)
			rx_bit = master ? pin_s.mosi : pin_s.miso;
		else
			rx_bit = master ? pin_s.miso : pin_s.mosi;
		s_d.sck_prev = pin_s.sck;

		// ****************************************
		// bus reads (a read clears before the engine may set again)
		// ****************************************
		access = i_wb.cyc && i_wb.stb && !s_q.wb.ack;
		wr = access && i_wb.we;
		s_d.wb.ack = access;
		if (access && !i_wb.we)
		begin
			unique case (i_wb.adr)
				ADDR_CONTROL_ONE: rdat = {16'h0000, s_q.control_one};
				ADDR_CONTROL_TWO: rdat = {16'h0000, s_q.control_two};
				ADDR_STATUS:
				begin
					rdat[ST_RX_NE] = s_q.rx_not_empty_flag;
					rdat[ST_TX_EMPTY] = s_q.tx_empty_flag;
					rdat[ST_BUSY] = busy;
				end
				ADDR_DATA:
				begin
					rdat = {16'h0000, s_q.rx_buf};
					s_d.rx_not_empty_flag = 1'b0;
				end
				default: rdat = 32'h0000_0000;
			endcase
		end
		s_d.wb.dat = rdat;

		// ****************************************
		// transfer engine
		// ****************************************
		if (!enabled)
		begin
			// disabling ends any frame at once
			s_d.active = 1'b0;
			s_d.bit_cnt = 5'd0;
			s_d.edge_cnt = 6'd0;
			s_d.div_cnt = 8'h00;
		end
		else if (!s_q.active)
		begin
			if (master)
				start = (tx_mode && !s_q.tx_empty_flag) || rx_mode;
			else
				start = !pin_s.slave_select_n;
			if (start)
			begin
				s_d.active = 1'b1;
				s_d.bit_cnt = 5'd0;
				s_d.edge_cnt = 6'd0;
				s_d.div_cnt = 8'h00;
				s_d.rx_sr = 16'h0000;
				if (tx_mode && !s_q.tx_empty_flag)
				begin
					s_d.tx_sr = s_q.tx_buf;
					s_d.tx_empty_flag = 1'b1;
				end
				else
				begin
					// slave with nothing loaded resends the old buffer
					s_d.tx_sr = (master || !tx_mode) ? 16'h0000 : s_q.tx_buf;
				end
			end
		end
		else
		begin
			if (master)
			begin
				ev = (s_q.div_cnt == 8'(SCK_HALF - 1));
				lead = !s_q.edge_cnt[0];
				s_d.div_cnt = ev ? 8'h00 : s_q.div_cnt + 8'h01;
			end
			else
			begin
				// only the synchronised level and its last value are compared
				ev = (pin_s.sck != s_q.sck_prev);
				lead = (pin_s.sck != clock_idle_level);
				if (pin_s.slave_select_n)
					s_d.active = 1'b0;
			end
			sample = lead ^ clock_sample_phase;
			if (ev)
			begin
				if (master)
				begin
					s_d.pins.sck_o = !s_q.pins.sck_o;
					s_d.edge_cnt = s_q.edge_cnt + 6'd1;
					if (s_d.edge_cnt == {len, 1'b0})
						s_d.active = 1'b0;
				end
				if (sample)
				begin
					s_d.rx_sr = rx_insert(s_q.rx_sr, rx_bit, lsb_first, wide);
					s_d.bit_cnt = s_q.bit_cnt + 5'd1;
					if (s_d.bit_cnt == len)
					begin
						s_d.rx_buf = wide ? s_d.rx_sr : {8'h00, s_d.rx_sr[7:0]};
						s_d.rx_not_empty_flag = 1'b1;
						if (!master)
							s_d.active = 1'b0;
					end
				end
				else if (s_q.bit_cnt != 5'd0 && s_q.bit_cnt != len)
				begin
					s_d.tx_sr = tx_shift(s_q.tx_sr, lsb_first);
				end
			end
		end
		if (!master || !s_d.active)
			s_d.pins.sck_o = clock_idle_level;

		// ****************************************
		// pins
		// ****************************************
		tx_drive = enabled && tx_mode && (master || !pin_s.slave_select_n);
		s_d.pins.mosi_o = out_bit(s_d.tx_sr, lsb_first, wide);
		s_d.pins.miso_o = out_bit(s_d.tx_sr, lsb_first, wide);
		s_d.pins.mosi_oe = master && tx_drive;
		s_d.pins.miso_oe = !master && tx_drive;
		s_d.pins.sck_oe = enabled && master;

		// ****************************************
		// bus writes (a data write after a load leaves the buffer full)
		// ****************************************
		if (wr)
		begin
			unique case (i_wb.adr)
				ADDR_CONTROL_ONE: s_d.control_one = merge16(s_q.control_one, i_wb.dat, i_wb.sel);
				ADDR_CONTROL_TWO: s_d.control_two = merge16(s_q.control_two, i_wb.dat, i_wb.sel);
				ADDR_DATA:
				begin
					s_d.tx_buf = merge16(s_q.tx_buf, i_wb.dat, i_wb.sel);
					s_d.tx_empty_flag = 1'b0;
				end
				default: s_d.tx_buf = s_q.tx_buf;
			endcase
		end
		s_d.irq = s_d.rx_not_empty_flag && s_d.control_two[C2_RXNE_IE];
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			s_q <= '0;
			s_q.control_one <= CONTROL_ONE_RST;
			s_q.control_two <= CONTROL_TWO_RST;
			s_q.tx_empty_flag <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign o_wb = s_q.wb;
	assign o_pins = s_q.pins;
	assign o_rx_irq = s_q.irq;

endmodule

// ===== bench/spi_engine_monitor.sv
// checker: port-level assertions for the spi transfer engine
module spi_engine_monitor
	import spi_engine_pkg::*;
#(
	parameter int SCK_HALF = SCK_HALF_CYC
)
(
	input wire logic          i_core_clk,
	input wire logic          i_rst,
	input wire wb_req_s       i_wb,
	input wire wb_rsp_s       o_wb,
	input wire spi_pins_in_s  i_pins,
	input wire spi_pins_out_s o_pins,
	input wire logic          o_rx_irq
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	logic       take;
	logic       sck_q;
	logic [7:0] gap_q;

	assign take = i_wb.cyc && i_wb.stb && !o_wb.ack;

	// cycles since the last sck change, saturating so long idle gaps never wrap
	always_ff @(posedge i_core_clk)
	begin
		sck_q <= o_pins.sck_o;
		if (i_rst || o_pins.sck_o != sck_q)
			gap_q <= 8'h00;
		else if (gap_q != 8'hff)
			gap_q <= gap_q + 8'h01;
	end

	ack_answer_a: assert property (take |=> o_wb.ack)
		else $error("request not answered next cycle");
	ack_pulse_a: assert property (o_wb.ack |=> !o_wb.ack)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (o_wb.ack |-> $past(take))
		else $error("ack without a request");
	upper_zero_a: assert property (o_wb.ack |-> o_wb.dat[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	unmapped_zero_a: assert property (take && !i_wb.we && i_wb.adr == 8'h10 |=> o_wb.dat == 32'h0)
		else $error("unmapped read not zero");
	one_driver_a: assert property (!(o_pins.mosi_oe && o_pins.miso_oe))
		else $error("both data lines driven");
	master_miso_a: assert property (o_pins.sck_oe |-> !o_pins.miso_oe)
		else $error("master drives its receive line");
	sck_half_a: assert property (o_pins.sck_oe && o_pins.sck_o != sck_q |-> gap_q >= 8'(SCK_HALF - 1))
		else $error("sck half period too short");
	irq_flag_a: assert property (take && !i_wb.we && i_wb.adr == ADDR_STATUS && o_rx_irq
		|=> o_wb.dat[ST_RX_NE])
		else $error("interrupt without receive flag");
endmodule

bind spi_engine spi_engine_monitor #(.SCK_HALF(SCK_HALF)) monitor (.i_core_clk(i_core_clk),
	.i_rst(i_rst), .i_wb(i_wb), .o_wb(o_wb), .i_pins(i_pins), .o_pins(o_pins),
	.o_rx_irq(o_rx_irq));

// ===== bench/spi_far_slave.sv
// far-side spi slave model: mode 0, msb first, fixed reply word
module spi_far_slave
#(
	parameter logic [15:0] TX = 16'h0000
)
(
	input  wire logic        i_sck,
	input  wire logic        i_slave_select_n,
	input  wire logic        i_mosi,
	output logic             o_miso,
	output logic      [15:0] o_rx
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] sr;

	initial
	begin
		sr = TX;
		o_miso = 1'b0;
		o_rx = 16'h0000;
	end
	always @(negedge i_slave_select_n)
	begin
		sr = TX;
		o_miso = TX[15];
		o_rx = 16'h0000;
	end
	always @(posedge i_sck)
		if (!i_slave_select_n)
			o_rx = {o_rx[14:0], i_mosi};
	always @(negedge i_sck)
		if (!i_slave_select_n)
		begin
			sr = {sr[14:0], 1'b0};
			o_miso = sr[15];
		end
	// no pull on the line: once released it must not keep the last bit
	always @(posedge i_slave_select_n)
		o_miso = ~o_miso;
endmodule

// ===== bench/test_spi_engine.sv
// testbench: spi engine registers, master frames and line modes
module test_spi_engine
	import spi_engine_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic          i_core_clk;
	logic          i_rst;
	wb_req_s       req;
	wb_rsp_s       rsp;
	spi_pins_in_s  pin_in;
	spi_pins_out_s pin_out;
	logic          rx_irq;
	logic          sel_n;
	logic          far_miso;
	logic          flip = 1'b0;
	logic          ext_sck;
	logic          ext_mosi;
	logic          ext_on;
	logic [15:0]   far_rx;
	int            num_errors;
	int            cmp_count;

	assign pin_in = '{sck: pin_out.sck_oe ? pin_out.sck_o : ext_sck, slave_select_n: sel_n,
		mosi: pin_out.mosi_oe ? pin_out.mosi_o : (ext_on ? ext_mosi : flip),
		miso: pin_out.miso_oe ? pin_out.miso_o : far_miso};

	spi_engine #(.SCK_HALF(4)) DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_wb(req),
		.o_wb(rsp), .i_pins(pin_in), .o_pins(pin_out), .o_rx_irq(rx_irq));
	spi_far_slave #(.TX(16'h3c5a)) far (.i_sck(pin_in.sck), .i_slave_select_n(sel_n),
		.i_mosi(pin_in.mosi), .o_miso(far_miso), .o_rx(far_rx));

	initial
	begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	// undriven mosi wanders instead of holding a stale level
	always @(posedge i_core_clk)
		flip <= ~flip;

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic stop_test;
		$display("errors %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge i_core_clk);
		req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'h3, adr: a, dat: d};
		// ack and data are read as they stand at the edge, before the slave updates them
		do
		begin
			@(posedge i_core_clk);
			n++;
		end
		while (rsp.ack !== 1'b1 && n < 20);
		if (n >= 20)
			num_errors++;
		r = rsp.dat;
		req <= '0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, a, d, r);
	endtask

	task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		wb(1'b0, a, 32'h0, r);
		chk(name, exp, r);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic s_reset;
		rd("control_one", ADDR_CONTROL_ONE, 32'h0);
		rd("control_two", ADDR_CONTROL_TWO, 32'h0);
		rd("status", ADDR_STATUS, 32'h1 << ST_TX_EMPTY);
		wr(ADDR_STATUS, 32'hffff);
		rd("status kept", ADDR_STATUS, 32'h1 << ST_TX_EMPTY);
		rd("unmapped", 8'h10, 32'h0);
		@(negedge i_core_clk);
		chk("sck idle", 32'h0, {30'h0, pin_out.sck_o, pin_out.sck_oe});
	endtask

	task automatic frame(input logic [15:0] ctl, input logic [15:0] tx,
		input logic [15:0] far_exp, input logic [15:0] rx_exp);
		int n;
		logic [31:0] r;
		n = 0;
		wr(ADDR_CONTROL_ONE, {16'h0, ctl});
		rd("control_one", ADDR_CONTROL_ONE, {16'h0, ctl});
		sel_n <= 1'b0;
		wr(ADDR_DATA, {16'h0, tx});
		rd("status run", ADDR_STATUS, (32'h1 << ST_BUSY) | (32'h1 << ST_TX_EMPTY));
		do
		begin
			wb(1'b0, ADDR_STATUS, 32'h0, r);
			n++;
		end
		while (r[ST_RX_NE] !== 1'b1 && n < 100);
		chk("rx ready", 32'h1, {31'h0, r[ST_RX_NE]});
		@(negedge i_core_clk);
		chk("irq", 32'h1, {31'h0, rx_irq});
		chk("far rx", {16'h0, far_exp}, {16'h0, far_rx});
		rd("data", ADDR_DATA, {16'h0, rx_exp});
		rd("status idle", ADDR_STATUS, 32'h1 << ST_TX_EMPTY);
		@(negedge i_core_clk);
		chk("irq clear", 32'h0, {31'h0, rx_irq});
		sel_n <= 1'b1;
		wr(ADDR_CONTROL_ONE, 32'h0);
	endtask

	task automatic s_modes;
		logic [15:0] ctl [8] = '{16'h0044, 16'h0444, 16'hc044, 16'h8044,
			16'h0040, 16'h0440, 16'hc040, 16'h8040};
		// mosi_oe, miso_oe, sck_oe, busy
		logic [3:0]  pin_exp [8] = '{4'b1010, 4'b0011, 4'b1010, 4'b0011,
			4'b0101, 4'b0001, 4'b0101, 4'b0001};
		logic [31:0] r;
		sel_n <= 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			wr(ADDR_CONTROL_ONE, {16'h0, ctl[i]});
			repeat (2) @(posedge i_core_clk);
			@(negedge i_core_clk);
			chk("pin enables", {29'h0, pin_exp[i][3:1]},
				{29'h0, pin_out.mosi_oe, pin_out.miso_oe, pin_out.sck_oe});
			wb(1'b0, ADDR_STATUS, 32'h0, r);
			chk("busy", {31'h0, pin_exp[i][0]}, {31'h0, r[ST_BUSY]});
			wr(ADDR_CONTROL_ONE, 32'h0);
			@(negedge i_core_clk);
			chk("sck stop", 32'h0, {30'h0, pin_out.sck_o, pin_out.sck_oe});
		end
		sel_n <= 1'b1;
	endtask

	task automatic s_bidir_tx;
		int n;
		logic [31:0] r;
		n = 0;
		wr(ADDR_CONTROL_ONE, 32'h0000_c044);
		sel_n <= 1'b0;
		wr(ADDR_DATA, 32'h0000_0069);
		do
		begin
			wb(1'b0, ADDR_STATUS, 32'h0, r);
			n++;
		end
		while ((r[ST_TX_EMPTY] !== 1'b1 || r[ST_BUSY] !== 1'b0) && n < 100);
		chk("bidir done", 32'h2, r & 32'h82);
		chk("bidir far rx", 32'h69, {16'h0, far_rx});
		sel_n <= 1'b1;
		wr(ADDR_CONTROL_ONE, 32'h0);
	endtask

	// bench acts as external master in mode 3; its 125 ns clock is off the core grid
	task automatic s_slave;
		logic [7:0] got;
		logic [7:0] word;
		word = 8'h96;
		got = 8'h00;
		ext_on <= 1'b1;
		ext_sck <= 1'b1;
		wr(ADDR_CONTROL_ONE, 32'h0000_0043);
		wr(ADDR_DATA, 32'h0000_00c3);
		sel_n <= 1'b0;
		repeat (8) @(posedge i_core_clk);
		// offset keeps every link edge away from a core clock edge
		#1ns;
		for (int i = 7; i >= 0; i--)
		begin
			ext_sck = 1'b0;
			ext_mosi = word[i];
			#62.5ns;
			ext_sck = 1'b1;
			got[i] = pin_in.miso;
			#62.5ns;
		end
		chk("slave miso", 32'h00c3, {24'h0, got});
		rd("slave data", ADDR_DATA, 32'h0096);
		sel_n <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		rd("slave idle", ADDR_STATUS, 32'h1 << ST_TX_EMPTY);
	endtask

	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial
	begin
		i_rst = 1'b1;
		req = '0;
		sel_n = 1'b1;
		ext_sck = 1'b0;
		ext_mosi = 1'b0;
		ext_on = 1'b0;
		num_errors = 0;
		cmp_count = 0;
		repeat (6) @(posedge i_core_clk);
		i_rst <= 1'b0;
		s_reset();
		wr(ADDR_CONTROL_TWO, 32'h1 << C2_RXNE_IE);
		frame(16'h0044, 16'h00a5, 16'h00a5, 16'h003c);
		frame(16'h08c4, 16'h1234, 16'h2c48, 16'h5a3c);
		s_bidir_tx();
		s_modes();
		s_slave();
		stop_test();
	end

	initial
	begin
		#50us;
		num_errors++;
		stop_test();
	end
endmodule
